//--- src/cpmc_top.sv
`timescale 1ns/1ps
// One channel of mode control; a second channel is a second instance.
module cpmc_top #(
  parameter logic [11:0] DEVICE_ID = 12'h5A5, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary value.
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [3:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RVALID,
  output logic INPUT_MON_EN,
  output logic FREQ_MON_EN,
  output logic AUTO_SWITCH_EN,
  output logic DIGITAL_LOOP_PWR,
  output logic MODULATOR_EN,
  output logic NCO_FREQ_EN,
  output logic [2:0] ANALOG_REF_SEL,
  output logic [1:0] LOCK_INPUT_SEL,
  output logic XTAL_DRIVER_EN,
  output logic OSC_SINGLE_EN,
  output logic DOUBLER_EN,
  output logic [1:0] MASTER_CLK_SEL,
  output logic [1:0] CHANNEL_MODE
);
  logic loop_enable_reg, loop_enable_next;
  logic [2:0] ref_sel_reg, ref_sel_next;
  logic [1:0] osc_mode_reg, osc_mode_next;
  logic doubler_reg, doubler_next;
  logic [1:0] mclk_reg, mclk_next;
  cpmc_pkg::cpmc_sub_t sub_reg, sub_next;
  logic [1:0] lock_sel_reg, lock_sel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic rd_src_mem_reg, rd_src_mem_next;
  logic [7:0] mem_rdata;
  logic mem_wr;
  cpmc_pkg::cpmc_mode_t mode;
  logic in_mon_reg, freq_mon_reg, auto_sw_reg, dig_pwr_reg, mod_reg, nco_reg;
  logic xtal_reg, single_reg;
  logic [1:0] mode_reg;

  // Combined mode needs the top two selector bits set and the loop enabled.
  function automatic cpmc_pkg::cpmc_mode_t decode_mode(input logic [2:0] sel, input logic en);
    if (!sel[2]) begin
      decode_mode = cpmc_pkg::CPMC_MODE_ANALOG;
    end else if (sel[1] && en) begin
      decode_mode = cpmc_pkg::CPMC_MODE_COMBINED;
    end else begin
      decode_mode = cpmc_pkg::CPMC_MODE_INVALID;
    end
  endfunction : decode_mode

  // Registers with no special meaning go to the plain store at offsets 8 and up.
  assign mem_wr = CFG_WR && CFG_ADDR[3];

  cpmc_regmem #(.DEPTH(cpmc_pkg::MEM_DEPTH), .WIDTH(8)) u_mem (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .wr_en(mem_wr),
    .addr(CFG_ADDR),
    .wdata(CFG_WDATA),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Configuration writes and reads; only this port reaches this state.
  always_comb begin
    loop_enable_next = loop_enable_reg;
    ref_sel_next = ref_sel_reg;
    osc_mode_next = osc_mode_reg;
    doubler_next = doubler_reg;
    mclk_next = mclk_reg;
    sub_next = sub_reg;
    lock_sel_next = lock_sel_reg;
    rdata_next = rdata_reg;
    rvalid_next = CFG_RD && !CFG_WR;
    // The source only moves on an accepted read, so register data stand until the next read.
    rd_src_mem_next = (CFG_RD && !CFG_WR) ? CFG_ADDR[3] : rd_src_mem_reg;
    if (CFG_WR) begin
      case (CFG_ADDR)
        cpmc_pkg::ADDR_LOOP_ENABLE: loop_enable_next = CFG_WDATA[cpmc_pkg::LOOP_EN_BIT];
        cpmc_pkg::ADDR_ANALOG_CTRL_THREE: ref_sel_next = CFG_WDATA[2:0];
        cpmc_pkg::ADDR_MASTER_CFG_ONE: begin
          osc_mode_next = CFG_WDATA[1:0];
          doubler_next = CFG_WDATA[cpmc_pkg::DOUBLER_BIT];
        end
        cpmc_pkg::ADDR_MASTER_CFG_TWO: mclk_next = CFG_WDATA[1:0];
        cpmc_pkg::ADDR_SUB_MODE: begin
          // An unused code falls back to jitter attenuation.
          sub_next = (CFG_WDATA[1:0] == 2'h1) ? cpmc_pkg::CPMC_SUB_NCO :
                     (CFG_WDATA[1:0] == 2'h2) ? cpmc_pkg::CPMC_SUB_SPREAD : cpmc_pkg::CPMC_SUB_JITTER;
          lock_sel_next = (CFG_WDATA[5:4] == 2'h3) ? 2'h0 : CFG_WDATA[5:4];
        end
        default: ;
      endcase
    end else if (CFG_RD) begin
      case (CFG_ADDR)
        // Identification is read-only: writes above never touch it.
        cpmc_pkg::ADDR_IDENT_ONE: rdata_next = DEVICE_ID[11:4];
        cpmc_pkg::ADDR_IDENT_TWO: rdata_next = {DEVICE_ID[3:0], REVISION};
        cpmc_pkg::ADDR_LOOP_ENABLE: rdata_next = {7'h00, loop_enable_reg};
        cpmc_pkg::ADDR_ANALOG_CTRL_THREE: rdata_next = {5'h00, ref_sel_reg};
        cpmc_pkg::ADDR_MASTER_CFG_ONE: rdata_next = {5'h00, doubler_reg, osc_mode_reg};
        cpmc_pkg::ADDR_MASTER_CFG_TWO: rdata_next = {6'h00, mclk_reg};
        cpmc_pkg::ADDR_SUB_MODE: rdata_next = {2'h0, lock_sel_reg, 2'h0, sub_reg};
        cpmc_pkg::ADDR_STATUS: rdata_next = {6'h00, mode_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      loop_enable_reg <= 1'b0;
      ref_sel_reg <= cpmc_pkg::REF_SEL_RESET;
      osc_mode_reg <= cpmc_pkg::OSC_MODE_RESET;
      doubler_reg <= 1'b0;
      mclk_reg <= cpmc_pkg::MCLK_RESET;
      sub_reg <= cpmc_pkg::CPMC_SUB_JITTER;
      lock_sel_reg <= 2'h0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rd_src_mem_reg <= 1'b0;
    end else begin
      loop_enable_reg <= loop_enable_next;
      ref_sel_reg <= ref_sel_next;
      osc_mode_reg <= osc_mode_next;
      doubler_reg <= doubler_next;
      mclk_reg <= mclk_next;
      sub_reg <= sub_next;
      lock_sel_reg <= lock_sel_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      rd_src_mem_reg <= rd_src_mem_next;
    end
  end

  // ==========================================================
  // Mode decode, re-evaluated every cycle from the stored fields.
  assign mode = decode_mode(ref_sel_reg, loop_enable_reg);

  logic in_mon_next, freq_mon_next, auto_sw_next, dig_pwr_next, mod_next, nco_next;
  logic xtal_next, single_next;
  logic [1:0] mode_next;
  always_comb begin
    in_mon_next = 1'b0;
    freq_mon_next = 1'b0;
    auto_sw_next = 1'b0;
    dig_pwr_next = 1'b0;
    mod_next = 1'b0;
    nco_next = 1'b0;
    mode_next = mode;
    if (mode == cpmc_pkg::CPMC_MODE_COMBINED) begin
      case (sub_reg)
        cpmc_pkg::CPMC_SUB_JITTER: begin
          in_mon_next = 1'b1;
          freq_mon_next = 1'b1;
          auto_sw_next = 1'b1;
          dig_pwr_next = 1'b1;
        end
        // The loop keeps only its output stage powered in these two.
        cpmc_pkg::CPMC_SUB_NCO: nco_next = 1'b1;
        cpmc_pkg::CPMC_SUB_SPREAD: mod_next = 1'b1;
        default: ;
      endcase
    end
    xtal_next = (osc_mode_reg == cpmc_pkg::OSC_MODE_XTAL);
    single_next = (osc_mode_reg == cpmc_pkg::OSC_MODE_SINGLE);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      in_mon_reg <= 1'b0;
      freq_mon_reg <= 1'b0;
      auto_sw_reg <= 1'b0;
      dig_pwr_reg <= 1'b0;
      mod_reg <= 1'b0;
      nco_reg <= 1'b0;
      xtal_reg <= 1'b0;
      single_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else begin
      in_mon_reg <= in_mon_next;
      freq_mon_reg <= freq_mon_next;
      auto_sw_reg <= auto_sw_next;
      dig_pwr_reg <= dig_pwr_next;
      mod_reg <= mod_next;
      nco_reg <= nco_next;
      xtal_reg <= xtal_next;
      single_reg <= single_next;
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Outputs, all taken from flip-flops.
  assign CFG_RDATA = rd_src_mem_reg ? mem_rdata : rdata_reg;
  assign CFG_RVALID = rvalid_reg;
  assign INPUT_MON_EN = in_mon_reg;
  assign FREQ_MON_EN = freq_mon_reg;
  assign AUTO_SWITCH_EN = auto_sw_reg;
  assign DIGITAL_LOOP_PWR = dig_pwr_reg;
  assign MODULATOR_EN = mod_reg;
  assign NCO_FREQ_EN = nco_reg;
  assign ANALOG_REF_SEL = ref_sel_reg;
  assign LOCK_INPUT_SEL = lock_sel_reg;
  assign XTAL_DRIVER_EN = xtal_reg;
  assign OSC_SINGLE_EN = single_reg;
  assign DOUBLER_EN = doubler_reg;
  assign MASTER_CLK_SEL = mclk_reg;
  assign CHANNEL_MODE = mode_reg;

  // ==========================================================
  // Checks.
  a_analog_no_mon: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !$past(ref_sel_reg[2]) |-> !in_mon_reg && !freq_mon_reg && !dig_pwr_reg)
    else $error("Monitoring active in analog-only mode.");
  a_loop_off_pwr: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !loop_enable_reg |=> !dig_pwr_reg && !in_mon_reg && !mod_reg && !nco_reg)
    else $error("Digital loop powered while disabled.");
  a_combined_mode: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ref_sel_reg[2:1] == 2'h3 && loop_enable_reg) |=> mode_reg == 2'(cpmc_pkg::CPMC_MODE_COMBINED))
    else $error("Combined mode not entered.");
  a_invalid_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ref_sel_reg[2:1] == 2'h2) |=> !dig_pwr_reg && !nco_reg && !mod_reg)
    else $error("Loop powered on unmatched selector.");
  a_jitter_mon: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (mode == cpmc_pkg::CPMC_MODE_COMBINED && sub_reg == cpmc_pkg::CPMC_SUB_JITTER)
    |=> in_mon_reg && freq_mon_reg && auto_sw_reg)
    else $error("Input block not fully active.");
  a_nco_shut: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    nco_reg |-> !in_mon_reg && !dig_pwr_reg && !mod_reg && $past(sub_reg) == cpmc_pkg::CPMC_SUB_NCO)
    else $error("Input block on in oscillator mode.");
  a_spread_shut: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    mod_reg |-> !in_mon_reg && !auto_sw_reg && $past(sub_reg) == cpmc_pkg::CPMC_SUB_SPREAD)
    else $error("Spread mode gating wrong.");
  a_ident_read: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && !CFG_WR && CFG_ADDR == cpmc_pkg::ADDR_IDENT_TWO)
    |=> CFG_RVALID && CFG_RDATA == {DEVICE_ID[3:0], REVISION})
    else $error("Identification read wrong.");
  a_osc_mode: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_WR && CFG_ADDR == cpmc_pkg::ADDR_MASTER_CFG_ONE && CFG_WDATA[1:0] == 2'h1)
    |=> ##1 XTAL_DRIVER_EN && !OSC_SINGLE_EN)
    else $error("Crystal driver not enabled.");
endmodule : cpmc_top

//--- src/cpmc_pkg.sv
// Contract
// - Channel registers reached only through this channel's own configuration port.
// - Identical register map per channel, addressing starting at zero.
// - Separate reset and configuration state per channel.
// - Read-only 12-bit device id and 4-bit revision across two id registers.
// - Digital loop enable cleared powers down input monitor and digital loop.
// - Reference select MSB zero means analog-loop-only mode.
// - Analog-only mode gives no activity, frequency monitoring or jitter filtering.
// - Analog-only reference is crystal or any of three input clocks.
// - Combined mode needs select pattern 11x and digital loop enable set.
// - Combined mode enables activity, frequency monitor and automatic switching.
// - Jitter attenuation locks digital loop to one of three reference inputs.
// - Numeric oscillator mode shuts input block and most of digital loop.
// - Spread spectrum shuts input block, modulator sweeps output frequency.
// - Combined mode master clock near 100, 114.285 or 125 MHz per setting.
// - Master clock from oscillator pin directly or through clock doubler.
// - Oscillator pin mode 10 enables single-ended clock input.
// - Oscillator pin mode 01 enables crystal driver.
package cpmc_pkg;
  // ==========================================================
  // Register map, word addresses from zero.
  localparam logic [3:0] ADDR_IDENT_ONE = 4'h0;
  localparam logic [3:0] ADDR_IDENT_TWO = 4'h1;
  localparam logic [3:0] ADDR_LOOP_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_ANALOG_CTRL_THREE = 4'h3;
  localparam logic [3:0] ADDR_MASTER_CFG_ONE = 4'h4;
  localparam logic [3:0] ADDR_MASTER_CFG_TWO = 4'h5;
  localparam logic [3:0] ADDR_SUB_MODE = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam int MEM_DEPTH = 16;
  // ==========================================================
  // Field positions and reset values.
  localparam int LOOP_EN_BIT = 0;
  localparam int DOUBLER_BIT = 2;
  localparam logic [2:0] REF_SEL_RESET = 3'h0;
  localparam logic [1:0] OSC_MODE_RESET = 2'h2;
  localparam logic [1:0] OSC_MODE_SINGLE = 2'h2;
  localparam logic [1:0] OSC_MODE_XTAL = 2'h1;
  localparam logic [1:0] MCLK_RESET = 2'h0;
  // ==========================================================
  // Reference selector codes.
  localparam logic [2:0] REF_XTAL = 3'h0;
  typedef enum logic [1:0] {CPMC_SUB_JITTER, CPMC_SUB_NCO, CPMC_SUB_SPREAD} cpmc_sub_t;
  typedef enum logic [1:0] {CPMC_MODE_ANALOG, CPMC_MODE_COMBINED, CPMC_MODE_INVALID} cpmc_mode_t;
endpackage : cpmc_pkg

//--- src/cpmc_regmem.sv
`timescale 1ns/1ps
// Small register store for plain configuration words; read data registered.
module cpmc_regmem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rdata_reg;

  // ==========================================================
  // Storage and registered read; contents clear on this channel's reset only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rdata_reg <= '0;
    end else begin
      if (wr_en) begin
        mem_reg[addr] <= wdata;
      end
      rdata_reg <= mem_reg[addr];
    end
  end
  assign rdata = rdata_reg;
endmodule : cpmc_regmem

//--- testbench/tb_channel_pll_mode_control.sv
`timescale 1ns/1ps
module tb_channel_pll_mode_control;
  // ==========================================================
  // Signals for channel A and channel B.
  localparam logic [11:0] DEV_ID = 12'h3C7; // Arbitrary value.
  localparam logic [3:0] DEV_REV = 4'h9; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic rstn_b = 1'b0;
  logic wr = 1'b0;
  logic wr_b = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid, mon, fmon, asw, dlp, modu, numeric_osc_mode, xtal, osc1, dbl, mon_b;
  logic [2:0] rsel, rsel_b;
  logic [1:0] lsel, mclk, mode, mode_b;
  logic [7:0] lfsr = 8'h09;
  logic [7:0] store [8];
  logic [15:0] ent;
  logic [2:0] osc_cfg;
  logic [15:0] exp_q [$];
  int n_mismatch = 0;
  int samples_checked = 0;

  // Free-running 100 MHz system clock.
  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Two channels share address and data wires but not strobes or resets.
  cpmc_top #(.DEVICE_ID(DEV_ID), .REVISION(DEV_REV)) DUT (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .INPUT_MON_EN(mon),
    .FREQ_MON_EN(fmon), .AUTO_SWITCH_EN(asw), .DIGITAL_LOOP_PWR(dlp), .MODULATOR_EN(modu),
    .NCO_FREQ_EN(numeric_osc_mode), .ANALOG_REF_SEL(rsel), .LOCK_INPUT_SEL(lsel), .XTAL_DRIVER_EN(xtal),
    .OSC_SINGLE_EN(osc1), .DOUBLER_EN(dbl), .MASTER_CLK_SEL(mclk), .CHANNEL_MODE(mode)
  );
  // Channel B is only written, so its read strobe is tied low.
  cpmc_top #(.DEVICE_ID(DEV_ID), .REVISION(DEV_REV)) dut_b (
    .CLK_SYS(clk_sys), .RSTN(rstn_b), .CFG_WR(wr_b), .CFG_RD(1'b0), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(), .CFG_RVALID(), .INPUT_MON_EN(mon_b),
    .FREQ_MON_EN(), .AUTO_SWITCH_EN(), .DIGITAL_LOOP_PWR(), .MODULATOR_EN(),
    .NCO_FREQ_EN(), .ANALOG_REF_SEL(rsel_b), .LOCK_INPUT_SEL(), .XTAL_DRIVER_EN(),
    .OSC_SINGLE_EN(), .DOUBLER_EN(), .MASTER_CLK_SEL(), .CHANNEL_MODE(mode_b)
  );

  // ==========================================================
  // Helpers.
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    next_rand = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rand

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One bus cycle per falling edge; a read notes its expected data and mask.
  task automatic go(input logic [1:0] w, input logic r, input logic [3:0] a, input logic [7:0] d,
                    input logic [7:0] m);
    @(negedge clk_sys);
    {wr_b, wr} = w;
    rd = r;
    addr = a;
    wdata = d;
    if (r) begin
      exp_q.push_back({m, d});
    end
  endtask : go

  // Expected enables are derived from selector, loop enable and sub-mode.
  task automatic chk_mode(input logic [2:0] sel, input logic en, input logic [1:0] sub, input logic [1:0] lk);
    logic comb;
    logic [1:0] s;
    logic [1:0] m;
    comb = (sel[2:1] == 2'b11) && en;
    s = (sub == 2'h3) ? 2'h0 : sub;
    m = !sel[2] ? 2'h0 : (comb ? 2'h1 : 2'h2);
    cmp({mon, fmon, asw, dlp, modu, numeric_osc_mode, mode},
        {{4{comb && s == 2'h0}}, comb && s == 2'h2, comb && s == 2'h1, m});
    cmp({5'h00, rsel}, {5'h00, sel});
    if (comb && s == 2'h0) begin
      cmp({6'h00, lsel}, {6'h00, (lk == 2'h3) ? 2'h0 : lk});
    end
    go(2'b00, 1'b1, 4'h7, {6'h00, m}, 8'h03);
  endtask : chk_mode

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Read monitor: every read answer is matched against the oldest note.
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp(rdata, ~rdata);
      end else begin
        ent = exp_q.pop_front();
        cmp(rdata & ent[15:8], ent[7:0] & ent[15:8]);
      end
    end
  end

  // The whole sequence takes about 560 cycles, so 20,000 is ample.
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    rstn_b = 1'b1;
    go(2'b10, 1'b0, 4'h3, 8'h06, 8'h00);
    go(2'b10, 1'b0, 4'h2, 8'h01, 8'h00);
    go(2'b00, 1'b0, 4'h0, 8'h00, 8'h00);
    repeat (2) @(negedge clk_sys);
    cmp({3'h0, xtal, osc1, dbl, mclk}, 8'h08);
    chk_mode(3'h0, 1'b0, 2'h0, 2'h0);
    // Identity reads before and after writes that must not land.
    for (int k = 0; k < 2; k++) begin
      go(2'b00, 1'b1, 4'h0, DEV_ID[11:4], 8'hFF);
      go(2'b00, 1'b1, 4'h1, {DEV_ID[3:0], DEV_REV}, 8'hFF);
      go(2'b01, 1'b0, 4'h0, 8'hFF, 8'h00);
      go(2'b01, 1'b0, 4'h1, 8'hFF, 8'h00);
      go(2'b01, 1'b0, 4'h7, 8'hFF, 8'h00);
    end
    // Every selector, loop enable and sub-mode, written back to back.
    for (int i = 0; i < 64; i++) begin
      lfsr = next_rand(lfsr);
      go(2'b01, 1'b0, 4'h3, {5'h00, i[5:3]}, 8'h00);
      go(2'b01, 1'b0, 4'h2, {7'h00, i[2]}, 8'h00);
      go(2'b01, 1'b0, 4'h6, {2'h0, lfsr[1:0], 2'h0, i[1:0]}, 8'h00);
      go(2'b00, 1'b0, 4'h0, 8'h00, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk_mode(i[5:3], i[2], i[1:0], lfsr[1:0]);
    end
    // Oscillator pin mode, doubler and master clock field; jitter attenuation is the sub-mode left set.
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      // A crystal always gets the doubler, a pin oscillator never does here; other codes take bit 2 of i.
      osc_cfg = {(i[1:0] == 2'h1) || ((i[1:0] != 2'h2) && i[2]), i[1:0]};
      go(2'b01, 1'b0, 4'h4, {5'h00, osc_cfg}, 8'h00);
      // A random master clock code; only its two low bits are stored and read back.
      go(2'b01, 1'b0, 4'h5, lfsr, 8'h00);
      go(2'b00, 1'b1, 4'h4, {5'h00, osc_cfg}, 8'h07);
      go(2'b00, 1'b1, 4'h5, lfsr, 8'h03);
      go(2'b00, 1'b0, 4'h0, 8'h00, 8'h00);
      repeat (2) @(negedge clk_sys);
      cmp({3'h0, xtal, osc1, dbl, mclk},
          {3'h0, i[1:0] == 2'h1, i[1:0] == 2'h2, osc_cfg[2], lfsr[1:0]});
    end
    // Plain storage in the upper half of the map.
    for (int i = 8; i < 16; i++) begin
      lfsr = next_rand(lfsr);
      store[i - 8] = lfsr;
      go(2'b01, 1'b0, i[3:0], lfsr, 8'h00);
    end
    for (int i = 8; i < 16; i++) begin
      go(2'b00, 1'b1, i[3:0], store[i - 8], 8'hFF);
    end
    go(2'b00, 1'b0, 4'h0, 8'h00, 8'h00);
    repeat (2) @(negedge clk_sys);
    // Channel B kept its own setup through all of channel A's traffic.
    cmp({1'b0, mon_b, mode_b, 1'b0, rsel_b}, 8'h56);
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp({1'b0, mon, dlp, mode, rsel}, 8'h00);
    cmp({1'b0, mon_b, mode_b, 1'b0, rsel_b}, 8'h56);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp({3'h0, xtal, osc1, dbl, mclk}, 8'h08);
    chk_mode(3'h0, 1'b0, 2'h0, 2'h0);
    go(2'b00, 1'b1, 4'h0, DEV_ID[11:4], 8'hFF);
    go(2'b00, 1'b0, 4'h0, 8'h00, 8'h00);
    repeat (3) @(negedge clk_sys);
    cmp(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule : tb_channel_pll_mode_control
